/* verilog/sras_defs.vh */
// constants for the serial register access slave
// Notes on behaviour
// - master starts every frame: 15-bit address, direction bit, then whole bytes
// - chip select high: data pin released, serial clock ignored
// - command and write bits are sampled on serial clock rising edges
// - read data changes on falling edge if edge select 0, rising if 1
// - 3-wire after reset; 4-wire only when both mirrored mode bits written 1
// - 4-wire reads go out on miso, 3-wire reads on the shared data pin
// - chip select low for the whole frame; data pin starts as input
// - address bits first, msb first, then direction bit, 1 read 0 write
// - after sixteen command bits the addressed byte is loaded and shifted out
// - 3-wire read turns the shared data pin to output after the command
// - held read returns consecutive registers, one per eight clocks
// - one block read is at most 0xa7 bytes
// - each byte written to 0x01 to 0xa7, bar the id registers, is stored when its last bit arrives
// - multi-byte write steps the address after each payload byte
// - address ascend bit 1 increments, 0 decrements; default 1
// - bit order bit picks d7 or d0 first; default d7 first
// - both soft reset bits 1 reload 0x02 to 0xa7; bits self clear
// - in 3-wire mode miso stays low
`ifndef SRAS_DEFS_VH
`define SRAS_DEFS_VH

`define SRAS_ADDR_W      15
`define SRAS_CMD_LAST    4'hf
`define SRAS_BIT_LAST    4'h7
`define SRAS_BIT_ZERO    4'h0
`define SRAS_BIT_ONE     4'h1

`define SRAS_REG_CFG     15'h0000
`define SRAS_REG_TYPE    15'h0003
`define SRAS_REG_ID_LO   15'h0004
`define SRAS_REG_ID_HI   15'h0005
`define SRAS_REG_VER     15'h0006
`define SRAS_REG_MKR_LO  15'h000c
`define SRAS_REG_MKR_HI  15'h000d
`define SRAS_REG_FIRST   15'h0001
`define SRAS_REG_LAST    15'h00a7
`define SRAS_ADDR_STEP   15'h0001

`define SRAS_MEM_DEPTH   168
`define SRAS_SOFT_FIRST  2
`define SRAS_MEM_RST     8'h00
`define SRAS_READ_MAX    8'ha7
`define SRAS_BYTE_ONE    8'h01

`define SRAS_B_SRST      7
`define SRAS_B_LSB       6
`define SRAS_B_ASC       5
`define SRAS_B_SDO       4
`define SRAS_B_SDO_M     3
`define SRAS_B_ASC_M     2
`define SRAS_B_LSB_M     1
`define SRAS_B_SRST_M    0

`define SRAS_LSB_RST     1'b0
`define SRAS_ASC_RST     1'b1
`define SRAS_SDO_RST     1'b0

`endif

/* verilog/sras_regmem.v */
// byte register store for the serial register access slave
`timescale 1ns/10ps
`include "sras_defs.vh"

module sras_regmem
#(
   parameter DEPTH      = `SRAS_MEM_DEPTH,
   parameter SOFT_FIRST = `SRAS_SOFT_FIRST
)
(
   input  wire       i_clock,
   input  wire       i_rst,
   input  wire       i_soft_rst,
   input  wire       i_we,
   input  wire [7:0] i_waddr,
   input  wire [7:0] i_wdata,
   input  wire [7:0] i_raddr,
   output reg  [7:0] o_rdata
);

   reg     [7:0] mem_r [0:DEPTH-1];
   integer       i;

   // ======================================================
   // storage, reset and soft reload
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem_r[i] <= `SRAS_MEM_RST;
      end
      else if (i_soft_rst)
      begin
         for (i = SOFT_FIRST; i < DEPTH; i = i + 1)
            mem_r[i] <= `SRAS_MEM_RST;
      end
      else if (i_we && (i_waddr < DEPTH))
         mem_r[i_waddr] <= i_wdata;
   end

   // ======================================================
   // registered read port
   always @(posedge i_clock)
   begin
      if (i_rst)
         o_rdata <= `SRAS_MEM_RST;
      else if (i_raddr < DEPTH)
         o_rdata <= mem_r[i_raddr];
      else
         o_rdata <= `SRAS_MEM_RST;
   end

endmodule // sras_regmem

/* verilog/sras_top.v */
// serial register access slave, 3-wire and 4-wire
`timescale 1ns/10ps
`include "sras_defs.vh"

module sras_top
#(
   parameter [7:0]  CHIP_TYPE = 8'h5a,    // arbitrary value
   parameter [15:0] CHIP_ID   = 16'h1234, // arbitrary value
   parameter [7:0]  CHIP_VER  = 8'h01,    // arbitrary value
   parameter [15:0] MAKER_ID  = 16'hbeef, // arbitrary value
   parameter [7:0]  READ_MAX  = `SRAS_READ_MAX
)
(
   input  wire i_clock,
   input  wire i_rst,
   input  wire i_sclk,
   input  wire i_chip_select_n,
   input  wire i_serial_data_io_in,
   input  wire i_read_edge_select,
   output wire o_serial_data_io_out,
   output reg  o_serial_data_io_oe,
   output wire o_miso,
   output reg  o_low_bit_first,
   output reg  o_addr_ascend,
   output reg  o_four_wire
);

   // ======================================================
   // input synchronisers
   reg  [2:0] sclk_q_r;
   reg  [1:0] cs_q_r;
   reg  [1:0] din_q_r;
   reg  [1:0] edge_q_r;

   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         sclk_q_r <= 3'h0;
         cs_q_r   <= 2'h3;
         din_q_r  <= 2'h0;
         edge_q_r <= 2'h0;
      end
      else
      begin
         sclk_q_r <= {sclk_q_r[1:0], i_sclk};
         cs_q_r   <= {cs_q_r[0], i_chip_select_n};
         din_q_r  <= {din_q_r[0], i_serial_data_io_in};
         edge_q_r <= {edge_q_r[0], i_read_edge_select};
      end
   end

   wire cs_n_s    = cs_q_r[1];
   wire din_s     = din_q_r[1];
   wire rd_edge_s = edge_q_r[1];
   wire sclk_rise = sclk_q_r[1] & ~sclk_q_r[2];
   wire sclk_fall = ~sclk_q_r[1] & sclk_q_r[2];

   // ======================================================
   // serial engine state
   reg  [3:0]               bit_cnt_r;
   reg                      cmd_done_r;
   reg                      is_read_r;
   reg  [14:0]              cmd_sr_r;
   reg  [`SRAS_ADDR_W-1:0]  addr_r;
   reg  [7:0]               in_sr_r;
   reg  [7:0]               out_sr_r;
   reg                      out_bit_r;
   reg                      fetch_r;
   reg  [7:0]               byte_cnt_r;
   reg                      over_r;
   reg                      srst_r;

   wire [7:0] mem_rdata;
   reg  [7:0] rd_byte;

   // ======================================================
   // decode helpers
   wire byte_end  = (bit_cnt_r == `SRAS_BIT_LAST);
   wire cmd_end   = (bit_cnt_r == `SRAS_CMD_LAST);
   wire data_rise = sclk_rise & cmd_done_r;
   wire wr_commit = data_rise & ~is_read_r & byte_end;

   wire [7:0] wbyte = o_low_bit_first ? {din_s, in_sr_r[7:1]}
                                      : {in_sr_r[6:0], din_s};

   wire id_hit = (addr_r == `SRAS_REG_TYPE)  | (addr_r == `SRAS_REG_ID_LO) |
                 (addr_r == `SRAS_REG_ID_HI) | (addr_r == `SRAS_REG_VER)   |
                 (addr_r == `SRAS_REG_MKR_LO) | (addr_r == `SRAS_REG_MKR_HI);

   wire in_store = (addr_r >= `SRAS_REG_FIRST) & (addr_r <= `SRAS_REG_LAST);
   wire mem_we   = wr_commit & in_store & ~id_hit;
   wire cfg_we   = wr_commit & (addr_r == `SRAS_REG_CFG);

   wire [`SRAS_ADDR_W-1:0] addr_step = o_addr_ascend ? addr_r + `SRAS_ADDR_STEP
                                                     : addr_r - `SRAS_ADDR_STEP;

   // store read address runs one byte ahead so a fetch needs no extra cycle
   wire [7:0] raddr = !cmd_done_r ? cmd_sr_r[7:0] : (is_read_r ? addr_step[7:0] : addr_r[7:0]);

   wire first_bit = o_low_bit_first ? rd_byte[0] : rd_byte[7];
   wire [7:0] rd_rest = o_low_bit_first ? {1'b0, rd_byte[7:1]}
                                        : {rd_byte[6:0], 1'b0};
   wire sr_bit = o_low_bit_first ? out_sr_r[0] : out_sr_r[7];
   wire [7:0] sr_rest = o_low_bit_first ? {1'b0, out_sr_r[7:1]}
                                        : {out_sr_r[6:0], 1'b0};

   // ======================================================
   // read data selection
   always @*
   begin
      rd_byte = `SRAS_MEM_RST;
      if (!over_r)
      begin
         case (addr_r)
            `SRAS_REG_CFG:
               rd_byte = {1'b0, o_low_bit_first, o_addr_ascend, o_four_wire,
                          o_four_wire, o_addr_ascend, o_low_bit_first, 1'b0};
            `SRAS_REG_TYPE:   rd_byte = CHIP_TYPE;
            `SRAS_REG_ID_LO:  rd_byte = CHIP_ID[7:0];
            `SRAS_REG_ID_HI:  rd_byte = CHIP_ID[15:8];
            `SRAS_REG_VER:    rd_byte = CHIP_VER;
            `SRAS_REG_MKR_LO: rd_byte = MAKER_ID[7:0];
            `SRAS_REG_MKR_HI: rd_byte = MAKER_ID[15:8];
            default:
            begin
               if (in_store)
                  rd_byte = mem_rdata;
               else
                  rd_byte = `SRAS_MEM_RST;
            end
         endcase
      end
   end

   // ======================================================
   // frame engine
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         bit_cnt_r           <= `SRAS_BIT_ZERO;
         cmd_done_r          <= 1'b0;
         is_read_r           <= 1'b0;
         cmd_sr_r            <= 15'h0000;
         addr_r              <= `SRAS_REG_CFG;
         in_sr_r             <= `SRAS_MEM_RST;
         out_sr_r            <= `SRAS_MEM_RST;
         out_bit_r           <= 1'b0;
         fetch_r             <= 1'b0;
         byte_cnt_r          <= `SRAS_MEM_RST;
         over_r              <= 1'b0;
         o_serial_data_io_oe <= 1'b0;
      end
      else if (cs_n_s)
      begin
         bit_cnt_r           <= `SRAS_BIT_ZERO;
         cmd_done_r          <= 1'b0;
         is_read_r           <= 1'b0;
         fetch_r             <= 1'b0;
         byte_cnt_r          <= `SRAS_MEM_RST;
         over_r              <= 1'b0;
         out_bit_r           <= 1'b0;
         o_serial_data_io_oe <= 1'b0;
      end
      else
      begin
         fetch_r <= 1'b0;
         if (fetch_r)
         begin
            if (rd_edge_s)
            begin
               out_bit_r <= first_bit;
               out_sr_r  <= rd_rest;
            end
            else
               out_sr_r <= rd_byte;
         end
         if (sclk_rise && !cmd_done_r)
         begin
            cmd_sr_r  <= {cmd_sr_r[13:0], din_s};
            bit_cnt_r <= bit_cnt_r + `SRAS_BIT_ONE;
            if (cmd_end)
            begin
               cmd_done_r <= 1'b1;
               bit_cnt_r  <= `SRAS_BIT_ZERO;
               addr_r     <= cmd_sr_r;
               is_read_r  <= din_s;
               if (din_s)
               begin
                  fetch_r             <= 1'b1;
                  byte_cnt_r          <= `SRAS_BYTE_ONE;
                  o_serial_data_io_oe <= ~o_four_wire;
               end
            end
         end
         else if (data_rise)
         begin
            bit_cnt_r <= byte_end ? `SRAS_BIT_ZERO : bit_cnt_r + `SRAS_BIT_ONE;
            if (is_read_r)
            begin
               if (rd_edge_s && !byte_end)
               begin
                  out_bit_r <= sr_bit;
                  out_sr_r  <= sr_rest;
               end
               if (byte_end)
               begin
                  fetch_r <= 1'b1;
                  if (byte_cnt_r < READ_MAX)
                  begin
                     addr_r     <= addr_step;
                     byte_cnt_r <= byte_cnt_r + `SRAS_BYTE_ONE;
                  end
                  else
                     over_r <= 1'b1;
               end
            end
            else
            begin
               in_sr_r <= wbyte;
               if (byte_end)
                  addr_r <= addr_step;
            end
         end
         if (sclk_fall && cmd_done_r && is_read_r && !rd_edge_s)
         begin
            out_bit_r <= sr_bit;
            out_sr_r  <= sr_rest;
         end
      end
   end

   // ======================================================
   // configuration byte with mirrored fields
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_low_bit_first <= `SRAS_LSB_RST;
         o_addr_ascend   <= `SRAS_ASC_RST;
         o_four_wire     <= `SRAS_SDO_RST;
         srst_r          <= 1'b0;
      end
      else
      begin
         srst_r <= cfg_we & wbyte[`SRAS_B_SRST] & wbyte[`SRAS_B_SRST_M];
         if (cfg_we)
         begin
            if (wbyte[`SRAS_B_LSB] == wbyte[`SRAS_B_LSB_M])
               o_low_bit_first <= wbyte[`SRAS_B_LSB];
            if (wbyte[`SRAS_B_ASC] == wbyte[`SRAS_B_ASC_M])
               o_addr_ascend <= wbyte[`SRAS_B_ASC];
            if (wbyte[`SRAS_B_SDO] == wbyte[`SRAS_B_SDO_M])
               o_four_wire <= wbyte[`SRAS_B_SDO];
         end
      end
   end

   // ======================================================
   // output pins
   assign o_serial_data_io_out = out_bit_r;

   // gate of flops only, so the read bit reaches miso with no extra cycle
   assign o_miso = o_four_wire & cmd_done_r & is_read_r & out_bit_r;

   // ======================================================
   // register store
   sras_regmem
   #(
      .DEPTH      (`SRAS_MEM_DEPTH),
      .SOFT_FIRST (`SRAS_SOFT_FIRST)
   )
   u_mem
   (
      .i_clock    (i_clock),
      .i_rst      (i_rst),
      .i_soft_rst (srst_r),
      .i_we       (mem_we),
      .i_waddr    (addr_r[7:0]),
      .i_wdata    (wbyte),
      .i_raddr    (raddr),
      .o_rdata    (mem_rdata)
   );

endmodule // sras_top

/* test/sras_properties.sv */
// port checker for the serial register access slave
`timescale 1ns/10ps
module sras_properties (
   input wire i_clock,
   input wire i_rst,
   input wire i_sclk,
   input wire i_chip_select_n,
   input wire i_serial_data_io_in,
   input wire i_read_edge_select,
   input wire o_serial_data_io_out,
   input wire o_serial_data_io_oe,
   input wire o_miso,
   input wire o_low_bit_first,
   input wire o_addr_ascend,
   input wire o_four_wire
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ==========================================
   // sequences
   sequence cs_idle;
      i_chip_select_n [*5];
   endsequence
   sequence rd_start;
      $rose(o_serial_data_io_oe);
   endsequence
   // ==========================================
   // properties
   a_pin_released: assert property (cs_idle |-> !o_serial_data_io_oe)
      else $error("data pin driven while deselected");
   a_miso_idle: assert property (cs_idle |-> !o_miso)
      else $error("miso active while deselected");
   a_cfg_frozen: assert property (cs_idle |-> $stable({o_low_bit_first, o_addr_ascend}))
      else $error("config changed while deselected");
   a_miso_three: assert property (!o_four_wire |-> !o_miso)
      else $error("miso active in three wire mode");
   a_oe_three: assert property (rd_start |-> !o_four_wire)
      else $error("data pin turned in four wire mode");
   a_oe_select: assert property (rd_start |-> $past(!i_chip_select_n, 3))
      else $error("data pin turned outside a frame");
   a_reset_values: assert property ($fell(i_rst) |-> !o_four_wire && o_addr_ascend
      && !o_low_bit_first && !o_miso && !o_serial_data_io_oe)
      else $error("wrong value after reset");
   a_cfg_in_frame: assert property (($changed(o_four_wire) || $changed(o_addr_ascend)
      || $changed(o_low_bit_first)) |-> $past(!i_chip_select_n, 2))
      else $error("config changed outside a frame");
endmodule // sras_properties

bind sras_top sras_properties sras_properties_inst (
   .i_clock(i_clock), .i_rst(i_rst), .i_sclk(i_sclk), .i_chip_select_n(i_chip_select_n),
   .i_serial_data_io_in(i_serial_data_io_in), .i_read_edge_select(i_read_edge_select),
   .o_serial_data_io_out(o_serial_data_io_out), .o_serial_data_io_oe(o_serial_data_io_oe),
   .o_miso(o_miso), .o_low_bit_first(o_low_bit_first), .o_addr_ascend(o_addr_ascend),
   .o_four_wire(o_four_wire));

/* test/sras_master_model.sv */
// serial master model that runs frames into the slave
`timescale 1ns/10ps
module sras_master_model (
   input  wire  i_out,
   input  wire  i_oe,
   input  wire  i_miso,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_pin
);
   logic [7:0] buf_q [0:167];
   logic       smp   [0:1535];
   logic       men, mdrv, flip;
   initial
   begin
      o_sclk = 0;
      o_cs_n = 1;
      men = 0;
      mdrv = 0;
      flip = 0;
   end
   always #40 flip = ~flip;
   // released pin has no pull, so it wanders
   assign o_pin = i_oe ? i_out : men ? mdrv : flip;
   // ==========================================
   // one frame: command, then n whole bytes
   task automatic xfer(input logic [14:0] a, input logic rd, es, lsb, four, input int n);
      logic [15:0] c;
      int          i, k;
      c = {a, rd};
      o_cs_n = 0;
      for (i = 0; i < 16 + 8 * n; i++)
      begin
         k = (i - 16) % 8;
         men = !(rd && i >= 16);
         mdrv = (i < 16) ? c[15 - i] : buf_q[(i - 16) / 8][lsb ? k : 7 - k];
         #160;
         if (!es) smp[i] = four ? i_miso : o_pin;
         o_sclk = 1;
         #160;
         if (es) smp[i] = four ? i_miso : o_pin;
         o_sclk = 0;
      end
      #160;
      o_cs_n = 1;
      men = 0;
      #320;
      for (i = 0; i < 8 * n; i++)
         buf_q[i / 8][lsb ? i % 8 : 7 - i % 8] = smp[16 + i - es];
   endtask
endmodule // sras_master_model

/* test/tb.sv */
// self-checking bench for the serial register access slave
`timescale 1ns/10ps
module tb;
   localparam logic [7:0]  TYPE_V = 8'h3c;    // arbitrary value
   localparam logic [15:0] ID_V   = 16'h7e11; // arbitrary value
   localparam logic [7:0]  VER_V  = 8'h02;    // arbitrary value
   localparam logic [15:0] MKR_V  = 16'h5aa5; // arbitrary value
   logic       i_clock = 0;
   logic       i_rst   = 1;
   logic       es      = 0;
   logic       up_e, lsb_e, four_e;
   wire        sclk, cs_n, pin, dout, oe, miso, lbf, asc, four;
   int         mismatches = 0;
   int         checked    = 0;
   logic [7:0] mem [0:167];
   always #20 i_clock = ~i_clock;
   sras_top #(.CHIP_TYPE(TYPE_V), .CHIP_ID(ID_V), .CHIP_VER(VER_V), .MAKER_ID(MKR_V))
      sras_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk), .i_chip_select_n(cs_n),
      .i_serial_data_io_in(pin), .i_read_edge_select(es), .o_serial_data_io_out(dout),
      .o_serial_data_io_oe(oe), .o_miso(miso), .o_low_bit_first(lbf),
      .o_addr_ascend(asc), .o_four_wire(four));
   sras_master_model sras_master_model_inst (.i_out(dout), .i_oe(oe), .i_miso(miso),
      .o_sclk(sclk), .o_cs_n(cs_n), .o_pin(pin));
   // ==========================================
   // expectations and checks
   function automatic logic [14:0] step(input logic [14:0] a);
      return up_e ? a + 15'h0001 : a - 15'h0001;
   endfunction
   function automatic logic ro(input logic [14:0] a);
      return a inside {[15'h0003:15'h0006], 15'h000c, 15'h000d};
   endfunction
   task automatic chk(input logic [7:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic frame(input logic [14:0] a, input logic rd, input int n);
      sras_master_model_inst.xfer(a, rd, es, lsb_e, four_e, n);
   endtask
   task automatic rd(input logic [14:0] a, input int n);
      int k;
      frame(a, 1, n);
      for (k = 0; k < n; k++)
      begin
         chk(sras_master_model_inst.buf_q[k], mem[a]);
         a = step(a);
      end
   endtask
   task automatic wr(input logic [14:0] a, input int n);
      logic [14:0] b;
      int          k;
      b = a;
      for (k = 0; k < n; k++)
      begin
         sras_master_model_inst.buf_q[k] = 8'($urandom);
         if (!ro(b))
            mem[b] = sras_master_model_inst.buf_q[k];
         b = step(b);
      end
      frame(a, 0, n);
   endtask
   task automatic cfg(input logic [7:0] v);
      int i;
      sras_master_model_inst.buf_q[0] = v;
      frame(15'h0000, 0, 1);
      if (v[6] == v[1]) lsb_e = v[6];
      if (v[5] == v[2]) up_e = v[5];
      if (v[4] == v[3]) four_e = v[4];
      if (v[7] && v[0])
         for (i = 2; i < 168; i++)
            mem[i] = ro(15'(i)) ? mem[i] : 8'h00;
      chk({5'h00, lbf, asc, four}, {5'h00, lsb_e, up_e, four_e});
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      int          i;
      logic [14:0] a;
      up_e = 1;
      lsb_e = 0;
      four_e = 0;
      for (i = 0; i < 168; i++)
         mem[i] = 8'h00;
      {mem[4], mem[3]} = {ID_V[7:0], TYPE_V};
      {mem[6], mem[5]} = {VER_V, ID_V[15:8]};
      {mem[13], mem[12]} = MKR_V;
      i = $urandom(32'h99d6_363e);
      repeat (5) @(posedge i_clock);
      #1 i_rst = 0;
      repeat (4) @(posedge i_clock);
      #13;
      chk({5'h00, lbf, asc, four}, 8'h02);
      wr(15'h0004, 2);
      rd(15'h0003, 4);
      rd(15'h000c, 2);
      for (i = 0; i < 6; i++)
      begin
         es = i[0];
         a = 15'h0010 + 15'($urandom % 144);
         wr(a, 1 + i % 3);
         rd(a, 1 + i % 3);
      end
      cfg(8'h10);
      cfg(8'h00);
      wr(15'h0050, 3);
      rd(15'h0050, 3);
      cfg(8'h66);
      wr(15'h0030, 2);
      rd(15'h0030, 2);
      cfg(8'h3c);
      rd(15'h0030, 2);
      cfg(8'hbd);
      rd(15'h0001, 167);
      report_and_stop();
   end
   initial
   begin
      #2000000;
      mismatches++;
      report_and_stop();
   end
endmodule // tb
